// ---- shared/fcps_regs.svh ----
// Register offsets, field positions, reset values and command codes of the flash sequencer
`ifndef FCPS_REGS_SVH
`define FCPS_REGS_SVH

// ************************************************************
// AXI4-Lite register byte offsets, then flash array addresses of the two option bytes
// ************************************************************
`define FCPS_OFF_CLKDIV   12'h000
`define FCPS_OFF_CMD      12'h004
`define FCPS_OFF_STAT     12'h008
`define FCPS_OFF_PROT     12'h00C
`define FCPS_OFF_OPT      12'h010
`define FCPS_OFF_ARRADDR  12'h014
`define FCPS_OFF_ARRDATA  12'h018
`define FCPS_OFF_SECCTL   12'h01C
`define FCPS_OFF_VECADDR  12'h020
`define FCPS_OFF_VECOUT   12'h024
`define FCPS_OFF_ACCESS   12'h028
`define FCPS_OFF_KEYLO    12'h02C
`define FCPS_OFF_KEYHI    12'h030
`define FCPS_OFF_KEYCHK   12'h034
`define FCPS_OFF_NVPROTA  16'hFFBD
`define FCPS_OFF_NVOPTA   16'hFFBF

// ************************************************************
// Status register fields
// ************************************************************
`define FCPS_STAT_CBEF    7
`define FCPS_STAT_CCF     6
`define FCPS_STAT_PVIOL   5
`define FCPS_STAT_ACCERR  4
`define FCPS_STAT_BLANK   2

// ************************************************************
// Option byte fields
// ************************************************************
`define FCPS_OPT_BACKDOOR_KEY_ENABLE    7
`define FCPS_OPT_NORED    6
`define FCPS_PROT_DIS     0
`define FCPS_SEC_OFF      2'b10

// ************************************************************
// Command codes
// ************************************************************
`define FCPS_CMD_BLANK    8'h05
`define FCPS_CMD_BYTE     8'h20
`define FCPS_CMD_BURST    8'h25
`define FCPS_CMD_PAGE     8'h40
`define FCPS_CMD_MASS     8'h41

// ************************************************************
// Geometry and reset values
// ************************************************************
`define FCPS_PAGE_BYTES   16'h0200
`define FCPS_VEC_LO       16'hFFC0
`define FCPS_VEC_HI       16'hFFFD
`define FCPS_TOP_ADDR     16'hFFFF
`define FCPS_FLASH_LO     16'hE000
`define FCPS_RAM_LO       16'h0060
`define FCPS_RAM_HI       16'h025F
`define FCPS_NONVOLATILE_OPTION_BYTE_RST    8'hFF
`define FCPS_PROTECTION_OPTION_BYTE_RST   8'hFF
`define FCPS_EXEC_CYCLES  8'h10

`endif

// ---- shared/fcps_pkg.sv ----
// Types shared by the flash sequencer design
package fcps_pkg;
   typedef enum logic [1:0] {
      FCPS_IDLE,
      FCPS_ARMED,
      FCPS_LOADED,
      FCPS_BUSY
   } fcps_seq_type;
endpackage

// ---- rtl/fcps_flash_seq.sv ----
// Flash command sequencer with block protection, vector redirection and security
`timescale 1ns/100ps
`default_nettype none
`include "fcps_regs.svh"

module fcps_flash_seq (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             eraseStart,
   output logic             programStart,
   output logic [15:0]      flashOpAddr,
   output logic [7:0]       flashOpData,
   output logic             flashSecured
);

   // ************************************************************
   // State
   // ************************************************************
   fcps_pkg::fcps_seq_type seq_r, seq_nxt;
   logic [7:0]  div_r, div_nxt;
   logic        divSet_r, divSet_nxt;
   logic [7:0]  cmd_r, cmd_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0]  data_r, data_nxt;
   logic        ccf_r, ccf_nxt;
   logic        accErr_r, accErr_nxt;
   logic        pViol_r, pViol_nxt;
   logic        blank_r, blank_nxt;
   logic [7:0]  execCnt_r, execCnt_nxt;
   logic [7:0]  protection_option_byte_r, protection_option_byte_nxt;
   logic [7:0]  nonvolatile_option_byte_r, nonvolatile_option_byte_nxt;
   logic [7:0]  workOpt_r, workOpt_nxt;
   logic        optLoaded_r, optLoaded_nxt;
   logic        keyOpen_r, keyOpen_nxt;
   logic [63:0] key_r, key_nxt;
   logic [63:0] keyChk_r, keyChk_nxt;
   logic        secCode_r, secCode_nxt;
   logic [15:0] vecIn_r, vecIn_nxt;
   logic [15:0] vecOut_r, vecOut_nxt;
   logic [15:0] accAddr_r, accAddr_nxt;
   logic        accOk_r, accOk_nxt;
   logic        erase_r, erase_nxt;
   logic        prog_r, prog_nxt;
   logic        secured_r, secured_nxt;
   logic [15:0] opAddr_r, opAddr_nxt;

   // AXI channel state
   logic        awHave_r, awHave_nxt;
   logic        wHave_r, wHave_nxt;
   logic [11:0] awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0]  wStrb_r, wStrb_nxt;
   logic        bValid_r, bValid_nxt;
   logic [1:0]  bResp_r, bResp_nxt;
   logic        rValid_r, rValid_nxt;
   logic [31:0] rData_r, rData_nxt;
   logic [1:0]  rResp_r, rResp_nxt;

   // ************************************************************
   // Combinational decode
   // ************************************************************
   logic        wrFire, rdFire, secureNow, protActive, protHit, redirect;
   logic [15:0] protLo, vecOff;
   logic        cmdValid;

   // Protected region runs from address (FPS+1)*512 up to top; FPS sits in bits 7:1
   always_comb begin
      protLo     = 16'({protection_option_byte_r[7:1], 9'h000}) + `FCPS_PAGE_BYTES;
      protActive = ~protection_option_byte_r[`FCPS_PROT_DIS];
      protHit    = protActive &&
                   (((addr_r >= protLo) || (addr_r >= `FCPS_VEC_LO)) ||
                    (cmd_r == `FCPS_CMD_MASS));
      // Partial only: protecting the whole array gives nowhere to redirect to
      redirect   = ~nonvolatile_option_byte_r[`FCPS_OPT_NORED] && protActive &&
                   (protLo > `FCPS_FLASH_LO);
      vecOff     = vecIn_r - `FCPS_VEC_LO;
      secureNow  = (workOpt_r[1:0] != `FCPS_SEC_OFF) && ~keyOpen_r;
      // Decode the captured word, not the live bus, which may already have moved on
      cmdValid   = (wData_r[7:0] == `FCPS_CMD_BLANK) || (wData_r[7:0] == `FCPS_CMD_BYTE) ||
                   (wData_r[7:0] == `FCPS_CMD_BURST) || (wData_r[7:0] == `FCPS_CMD_PAGE) ||
                   (wData_r[7:0] == `FCPS_CMD_MASS);
      wrFire     = awHave_r && wHave_r && ~bValid_r;
      rdFire     = s_axi_arvalid && ~rValid_r;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      seq_nxt = seq_r; div_nxt = div_r; divSet_nxt = divSet_r; cmd_nxt = cmd_r;
      addr_nxt = addr_r; data_nxt = data_r; ccf_nxt = ccf_r; accErr_nxt = accErr_r;
      pViol_nxt = pViol_r; blank_nxt = blank_r; execCnt_nxt = execCnt_r;
      protection_option_byte_nxt = protection_option_byte_r; nonvolatile_option_byte_nxt = nonvolatile_option_byte_r; workOpt_nxt = workOpt_r;
      optLoaded_nxt = 1'b1; keyOpen_nxt = keyOpen_r; key_nxt = key_r; keyChk_nxt = keyChk_r;
      secCode_nxt = secCode_r; vecIn_nxt = vecIn_r; vecOut_nxt = vecOut_r;
      accAddr_nxt = accAddr_r; accOk_nxt = accOk_r;
      erase_nxt = 1'b0; prog_nxt = 1'b0; secured_nxt = secureNow; opAddr_nxt = opAddr_r;
      awHave_nxt = awHave_r; wHave_nxt = wHave_r; awAddr_nxt = awAddr_r;
      wData_nxt = wData_r; wStrb_nxt = wStrb_r;
      bValid_nxt = bValid_r; bResp_nxt = bResp_r;
      rValid_nxt = rValid_r; rData_nxt = rData_r; rResp_nxt = rResp_r;

      // The nonvolatile option byte reaches the working register once, right after reset release
      if (!optLoaded_r) begin
         workOpt_nxt = nonvolatile_option_byte_r;
      end

      // Command execution countdown; model array work as a fixed delay
      if (seq_r == fcps_pkg::FCPS_BUSY) begin
         if (execCnt_r == 8'h00) begin
            seq_nxt = fcps_pkg::FCPS_IDLE;
            ccf_nxt = 1'b1;
            if (cmd_r == `FCPS_CMD_MASS) begin
               workOpt_nxt = `FCPS_NONVOLATILE_OPTION_BYTE_RST;
               nonvolatile_option_byte_nxt   = `FCPS_NONVOLATILE_OPTION_BYTE_RST;
               protection_option_byte_nxt  = `FCPS_PROTECTION_OPTION_BYTE_RST;
            end
         end else begin
            execCnt_nxt = execCnt_r - 8'h01;
         end
      end

      // AXI address and data capture in either order
      if (s_axi_awvalid && !awHave_r) begin
         awHave_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r) begin
         wHave_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (s_axi_bready && bValid_r) begin
         bValid_nxt = 1'b0;
      end

      // Register writes
      if (wrFire) begin
         awHave_nxt = 1'b0;
         wHave_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = 2'b00;
         if (wStrb_r[0]) begin
            unique case (awAddr_r)
               `FCPS_OFF_CLKDIV: begin
                  if (!divSet_r) begin
                     div_nxt    = wData_r[7:0];
                     divSet_nxt = 1'b1;
                  end
               end
               `FCPS_OFF_ARRADDR: accAddr_nxt = wData_r[15:0];
               `FCPS_OFF_SECCTL: secCode_nxt = wData_r[0];
               `FCPS_OFF_VECADDR: vecIn_nxt = wData_r[15:0];
               `FCPS_OFF_KEYLO: key_nxt[31:0] = wData_r;
               `FCPS_OFF_KEYHI: key_nxt[63:32] = wData_r;
               `FCPS_OFF_KEYCHK: begin
                  keyChk_nxt = {wData_r, keyChk_r[63:32]};
                  // Key only from secure code and only when enabled
                  if (secCode_r && workOpt_r[`FCPS_OPT_BACKDOOR_KEY_ENABLE] &&
                      ({wData_r, keyChk_r[63:32]} == key_r)) begin
                     keyOpen_nxt = 1'b1;
                  end
               end
               `FCPS_OFF_ARRDATA: begin
                  // Array write opens a sequence; blocked while secured from unsecure code
                  if (secureNow && !secCode_r) begin
                     bResp_nxt = 2'b00;
                  end else if (seq_r == fcps_pkg::FCPS_IDLE && !accErr_r && !pViol_r && divSet_r) begin
                     addr_nxt = accAddr_r;
                     data_nxt = wData_r[7:0];
                     seq_nxt  = fcps_pkg::FCPS_ARMED;
                  end else if (seq_r != fcps_pkg::FCPS_BUSY) begin
                     accErr_nxt = 1'b1;
                     seq_nxt    = fcps_pkg::FCPS_IDLE;
                  end
               end
               `FCPS_OFF_CMD: begin
                  if (seq_r == fcps_pkg::FCPS_ARMED && cmdValid) begin
                     cmd_nxt = wData_r[7:0];
                     seq_nxt = fcps_pkg::FCPS_LOADED;
                  end else if (seq_r != fcps_pkg::FCPS_BUSY) begin
                     accErr_nxt = 1'b1;
                     seq_nxt    = fcps_pkg::FCPS_IDLE;
                  end
               end
               `FCPS_OFF_STAT: begin
                  if (wData_r[`FCPS_STAT_ACCERR]) accErr_nxt = 1'b0;
                  if (wData_r[`FCPS_STAT_PVIOL]) pViol_nxt = 1'b0;
                  if (wData_r[`FCPS_STAT_CBEF] && seq_r == fcps_pkg::FCPS_LOADED) begin
                     if (protHit && cmd_r != `FCPS_CMD_BLANK) begin
                        pViol_nxt = 1'b1;
                        seq_nxt   = fcps_pkg::FCPS_IDLE;
                     end else begin
                        seq_nxt     = fcps_pkg::FCPS_BUSY;
                        ccf_nxt     = 1'b0;
                        execCnt_nxt = `FCPS_EXEC_CYCLES;
                        blank_nxt   = 1'b1;
                        erase_nxt   = (cmd_r == `FCPS_CMD_PAGE) || (cmd_r == `FCPS_CMD_MASS);
                        prog_nxt    = (cmd_r == `FCPS_CMD_BYTE) || (cmd_r == `FCPS_CMD_BURST);
                        // Page erase reports the page base
                        opAddr_nxt  = (cmd_r == `FCPS_CMD_PAGE) ? {addr_r[15:9], 9'h000} : addr_r;
                     end
                  end else if (!wData_r[`FCPS_STAT_CBEF] &&
                               (seq_r == fcps_pkg::FCPS_ARMED || seq_r == fcps_pkg::FCPS_LOADED)) begin
                     accErr_nxt = 1'b1;
                     seq_nxt    = fcps_pkg::FCPS_IDLE;
                  end
               end
               default: bResp_nxt = 2'b10;
            endcase
         end
      end

      // Register reads
      if (s_axi_rready && rValid_r) begin
         rValid_nxt = 1'b0;
      end
      if (rdFire) begin
         rValid_nxt = 1'b1;
         rResp_nxt  = 2'b00;
         rData_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            `FCPS_OFF_CLKDIV: rData_nxt = {23'h00_0000, divSet_r, div_r};
            `FCPS_OFF_CMD: rData_nxt = {24'h00_0000, cmd_r};
            `FCPS_OFF_STAT: rData_nxt = {24'h00_0000,
                                         seq_r == fcps_pkg::FCPS_IDLE || seq_r == fcps_pkg::FCPS_BUSY,
                                         ccf_r, pViol_r, accErr_r, 1'b0, blank_r, 2'b00};
            `FCPS_OFF_PROT: rData_nxt = {24'h00_0000, protection_option_byte_r};
            `FCPS_OFF_OPT: rData_nxt = {24'h00_0000, workOpt_r};
            `FCPS_OFF_ARRADDR: rData_nxt = {16'h0000, accAddr_r};
            `FCPS_OFF_ARRDATA: rData_nxt = {24'h00_0000, data_r};
            `FCPS_OFF_SECCTL: rData_nxt = {29'h0000_0000, keyOpen_r, secureNow, secCode_r};
            `FCPS_OFF_VECOUT: rData_nxt = {16'h0000, vecOut_r};
            `FCPS_OFF_ACCESS: rData_nxt = {31'h0000_0000, accOk_r};
            `FCPS_OFF_KEYLO, `FCPS_OFF_KEYHI, `FCPS_OFF_KEYCHK: rData_nxt = 32'h0000_0000;
            default: rResp_nxt = 2'b10;
         endcase
      end

      // Vector fetch resolution; reset vector always default
      if (redirect && vecIn_r >= `FCPS_VEC_LO && vecIn_r <= `FCPS_VEC_HI) begin
         vecOut_nxt = protLo - 16'h0040 + vecOff;
      end else begin
         vecOut_nxt = vecIn_r;
      end

      // Memory access permission for the probed address
      accOk_nxt = !(secureNow && !secCode_r &&
                    ((accAddr_r >= `FCPS_FLASH_LO) ||
                     (accAddr_r >= `FCPS_RAM_LO && accAddr_r <= `FCPS_RAM_HI)));
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         seq_r <= fcps_pkg::FCPS_IDLE; div_r <= 8'h00; divSet_r <= 1'b0; cmd_r <= 8'h00;
         addr_r <= 16'h0000; data_r <= 8'h00; ccf_r <= 1'b1; accErr_r <= 1'b0;
         pViol_r <= 1'b0; blank_r <= 1'b0; execCnt_r <= 8'h00;
         protection_option_byte_r <= `FCPS_PROTECTION_OPTION_BYTE_RST; nonvolatile_option_byte_r <= `FCPS_NONVOLATILE_OPTION_BYTE_RST; workOpt_r <= `FCPS_NONVOLATILE_OPTION_BYTE_RST;
         optLoaded_r <= 1'b0; keyOpen_r <= 1'b0; key_r <= 64'h0000_0000_0000_0000;
         keyChk_r <= 64'h0000_0000_0000_0000; secCode_r <= 1'b0; vecIn_r <= 16'h0000;
         vecOut_r <= 16'h0000; accAddr_r <= 16'h0000; accOk_r <= 1'b1;
         erase_r <= 1'b0; prog_r <= 1'b0; secured_r <= 1'b1; opAddr_r <= 16'h0000;
         awHave_r <= 1'b0; wHave_r <= 1'b0; awAddr_r <= 12'h000; wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0; bValid_r <= 1'b0; bResp_r <= 2'b00;
         rValid_r <= 1'b0; rData_r <= 32'h0000_0000; rResp_r <= 2'b00;
      end else begin
         seq_r <= seq_nxt; div_r <= div_nxt; divSet_r <= divSet_nxt; cmd_r <= cmd_nxt;
         addr_r <= addr_nxt; data_r <= data_nxt; ccf_r <= ccf_nxt; accErr_r <= accErr_nxt;
         pViol_r <= pViol_nxt; blank_r <= blank_nxt; execCnt_r <= execCnt_nxt;
         protection_option_byte_r <= protection_option_byte_nxt; nonvolatile_option_byte_r <= nonvolatile_option_byte_nxt; workOpt_r <= workOpt_nxt;
         optLoaded_r <= optLoaded_nxt; keyOpen_r <= keyOpen_nxt; key_r <= key_nxt;
         keyChk_r <= keyChk_nxt; secCode_r <= secCode_nxt; vecIn_r <= vecIn_nxt;
         vecOut_r <= vecOut_nxt; accAddr_r <= accAddr_nxt; accOk_r <= accOk_nxt;
         erase_r <= erase_nxt; prog_r <= prog_nxt; secured_r <= secured_nxt; opAddr_r <= opAddr_nxt;
         awHave_r <= awHave_nxt; wHave_r <= wHave_nxt; awAddr_r <= awAddr_nxt; wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt; bValid_r <= bValid_nxt; bResp_r <= bResp_nxt;
         rValid_r <= rValid_nxt; rData_r <= rData_nxt; rResp_r <= rResp_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Page erase reports the page base; data is not used for erase
   assign s_axi_awready = ~awHave_r;
   assign s_axi_wready  = ~wHave_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_arready = ~rValid_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rdata   = rData_r;
   assign s_axi_rresp   = rResp_r;
   assign eraseStart    = erase_r;
   assign programStart  = prog_r;
   assign flashOpAddr   = opAddr_r;
   assign flashOpData   = data_r;
   assign flashSecured  = secured_r;

endmodule
`default_nettype wire

// ---- verif/fcps_flash_seq_assertions.sv ----
// Concurrent checks on the flash sequencer ports
`timescale 1ns/100ps
`default_nettype none
module fcps_flash_seq_assertions (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        eraseStart,
   input wire logic        programStart,
   input wire logic        flashSecured
);
   // ************************************************************
   // Launch, security and bus handshake properties
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // Both write channels taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_prog_pulse_one: assert property (programStart |=> !programStart)
      else $error("program start held beyond one cycle");
   a_erase_pulse_one: assert property (eraseStart |=> !eraseStart)
      else $error("erase start held beyond one cycle");
   a_start_exclusive: assert property (!(eraseStart && programStart))
      else $error("erase and program launched together");
   // Erased option byte leaves the security pair engaged
   a_secure_at_release: assert property ($rose(rst_b) |-> flashSecured)
      else $error("security not engaged after reset");
   a_bresp_after_write: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_rvalid_after_ar: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed early");
endmodule
`default_nettype wire

// ---- verif/fcps_testbench.sv ----
// Self-checking bench for the flash sequencer over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "fcps_regs.svh"
module testbench;
   logic mclk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, eraseStart, programStart, flashSecured;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] flashOpAddr, lastAddr;
   logic [7:0]  flashOpData, lastData;
   int          n_mismatch = 0, samples_checked = 0, nProg = 0, nErase = 0;
   fcps_flash_seq uut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eraseStart(eraseStart),
      .programStart(programStart), .flashOpAddr(flashOpAddr), .flashOpData(flashOpData),
      .flashSecured(flashSecured));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   // Launch pulses last one cycle, so count them as they pass
   always @(negedge mclk) begin
      if (programStart === 1'b1 || eraseStart === 1'b1) begin
         lastAddr = flashOpAddr;
         lastData = flashOpData;
      end
      if (programStart === 1'b1) nProg++;
      if (eraseStart === 1'b1) nErase++;
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task hang;
      n_mismatch++;
      summarize();
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task do_reset;
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      int i;
      logic aT, wT;
      logic [1:0] r;
      @(posedge mclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      #0.1;
      // Ready is sampled settled before the edge, so each channel is released at its taking edge
      for (i = 0; i < 100 && (awvalid || wvalid); i++) begin
         aT = awvalid && awready === 1'b1;
         wT = wvalid && wready === 1'b1;
         @(posedge mclk);
         if (aT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
         #0.1;
      end
      for (i = 0; i < 100 && bvalid !== 1'b1; i++) begin
         @(posedge mclk);
         #0.1;
      end
      if (i == 100) hang();
      r = bresp;
      @(posedge mclk);
      bready <= 1'b0;
      #0.1;
      chk(r, 2'b00);
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      logic aT;
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      #0.1;
      for (i = 0; i < 100 && arvalid; i++) begin
         aT = arready === 1'b1;
         @(posedge mclk);
         if (aT) arvalid <= 1'b0;
         #0.1;
      end
      for (i = 0; i < 100 && rvalid !== 1'b1; i++) begin
         @(posedge mclk);
         #0.1;
      end
      if (i == 100) hang();
      d = rdata; r = rresp;
      @(posedge mclk);
      rready <= 1'b0;
      #0.1;
   endtask
   task setup;
      wr(`FCPS_OFF_SECCTL, 32'h0000_0001);
      wr(`FCPS_OFF_CLKDIV, 32'h0000_0013);
      wr(`FCPS_OFF_STAT, 32'h0000_0030);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_commands;
      logic [7:0]  code [5] = '{`FCPS_CMD_BYTE, `FCPS_CMD_BURST, `FCPS_CMD_PAGE, `FCPS_CMD_MASS, `FCPS_CMD_BLANK};
      logic [15:0] adr [5] = '{16'hE010, 16'hE011, 16'hE3FF, 16'hE123, 16'hE456};
      logic [15:0] expA [5] = '{16'hE010, 16'hE011, 16'hE200, 16'h0000, 16'h0000};
      logic [31:0] d;
      logic [1:0]  r;
      int k, i, p, e;
      for (k = 0; k < 5; k++) begin
         p = nProg; e = nErase;
         wr(`FCPS_OFF_ARRADDR, {16'h0000, adr[k]});
         wr(`FCPS_OFF_ARRDATA, 32'h0000_005A + k);
         wr(`FCPS_OFF_CMD, {24'h00_0000, code[k]});
         wr(`FCPS_OFF_STAT, 32'h0000_0080);
         for (i = 0; i < 60; i++) begin
            rd(`FCPS_OFF_STAT, d, r);
            if (d[`FCPS_STAT_CCF] === 1'b1) break;
         end
         chk(d[`FCPS_STAT_CCF], 1'b1);
         chk(nProg - p, k < 2);
         chk(nErase - e, k == 2 || k == 3);
         if (k < 3) chk(lastAddr, expA[k]);
         if (k < 2) chk(lastData, 8'h5A + k);
      end
   endtask
   // Abort by writing zero to the empty flag, or launch with no array write
   task t_refused(input bit skipArray);
      logic [31:0] d;
      logic [1:0]  r;
      int p;
      p = nProg + nErase;
      if (!skipArray) wr(`FCPS_OFF_ARRDATA, 32'h0000_0011);
      wr(`FCPS_OFF_CMD, {24'h00_0000, `FCPS_CMD_BYTE});
      wr(`FCPS_OFF_STAT, skipArray ? 32'h0000_0080 : 32'h0000_0000);
      rd(`FCPS_OFF_STAT, d, r);
      chk(d[`FCPS_STAT_ACCERR], 1'b1);
      chk(nProg + nErase - p, 0);
      wr(`FCPS_OFF_STAT, 32'h0000_0010);
      rd(`FCPS_OFF_STAT, d, r);
      chk(d[`FCPS_STAT_ACCERR], 1'b0);
   endtask
   task t_unmapped;
      logic [31:0] d;
      logic [1:0]  r;
      rd(12'h100, d, r);
      chk(r, 2'b10);
      chk(flashSecured, 1'b1);
   endtask
   initial begin
      do_reset();
      setup();
      t_commands();
      t_unmapped();
      t_refused(1'b0);
      do_reset();
      setup();
      t_refused(1'b1);
      summarize();
   end
   initial begin
      #400000;
      hang();
   end
endmodule
bind fcps_flash_seq fcps_flash_seq_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .eraseStart(eraseStart), .programStart(programStart),
   .flashSecured(flashSecured));
`default_nettype wire
